// ### rtl/bto_bridge.sv
`timescale 1ns/10ps
// Summary of operation
// [RQ1] Memory writes are posted into the queue
// [RQ2] I/O and config writes: retry, queue, delay
// [RQ3] All reads: retry and queue as delayed
// [RQ4] Read data returns opposite to its request
// [RQ5] Never join separate writes into one
// [RQ6] Never merge byte lanes across masked writes
// [RQ7] Never collapse same-address writes
// [RQ8] Only non-retry endings fix ordering place
// [RQ9] Retried requests may complete in any order
// [RQ10] Initiator serialises delayed requests needing order
// [RQ11] Initiator retries all requests fairly, independently
// [RQ12] Opposite directions unordered; both run together
// [RQ13] Posted acceptance never waits on own mastering
// [RQ14] Posted writes accepted whatever delayed state is
// [RQ15] Posted writes leave in arrival order
// [RQ16] Delayed read waits for earlier posted writes
// [RQ17] Read completion waits for earlier posted writes
// [RQ18] Delayed write never passes earlier posted writes
// [RQ19] Posted and delayed queues share turns fairly
// [RQ20] Delayed items pass freely; write completions pass posted
// [RQ21] Ordering only within one direction
// [RQ22] Software reads after writes for synchronisation
// [RQ23] Per direction: posted FIFO plus delayed queue
module bto_bridge #(
    parameter int PW_DEPTH = 4,
    parameter int DQ_DEPTH = 4
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic reset_in,
    // Bus clock pins: 0 primary, 1 secondary
    input wire logic [1:0] pci_clk_in,
    // Initiator side, indexed by direction: 0 downstream, 1 upstream
    input wire logic [1:0] init_valid_in,
    input wire logic [1:0][bto_pkg::CMD_W-1:0] init_cmd_in,
    input wire logic [1:0][bto_pkg::ADDR_W-1:0] init_addr_in,
    input wire logic [1:0][bto_pkg::DATA_W-1:0] init_data_in,
    input wire logic [1:0][bto_pkg::BE_W-1:0] init_be_in,
    output logic [1:0] init_ready_out,
    output logic [1:0] init_posted_out,
    output logic [1:0] init_retry_out,
    // Target side, indexed by direction
    output logic [1:0] tgt_valid_out,
    output logic [1:0] tgt_cmp_out,
    output logic [1:0][bto_pkg::CMD_W-1:0] tgt_cmd_out,
    output logic [1:0][bto_pkg::ADDR_W-1:0] tgt_addr_out,
    output logic [1:0][bto_pkg::DATA_W-1:0] tgt_data_out,
    output logic [1:0][bto_pkg::BE_W-1:0] tgt_be_out,
    input wire logic [1:0] tgt_ack_in,
    input wire logic [1:0] tgt_retry_in,
    input wire logic [1:0][bto_pkg::DATA_W-1:0] tgt_rdata_in
);
    localparam int IW = (DQ_DEPTH > 1) ? $clog2(DQ_DEPTH) : 1;
    localparam int CW = $clog2(PW_DEPTH + 2);
    localparam int FW = $clog2(PW_DEPTH + 1);
    localparam int PW = bto_pkg::POST_W;

    typedef struct packed {
        logic vld;
        logic cmp;
        logic [bto_pkg::CMD_W-1:0] cmd;
        logic [bto_pkg::ADDR_W-1:0] addr;
        logic [bto_pkg::DATA_W-1:0] data;
        logic [bto_pkg::BE_W-1:0] be;
        logic [CW-1:0] pend;
    } bto_dent_s;

    typedef struct packed {
        bto_dent_s [DQ_DEPTH-1:0] dq;
        logic busy;
        logic src_post;
        logic cmp;
        logic [IW-1:0] slot;
        logic [bto_pkg::SEQ_W-1:0] seq;
        logic [bto_pkg::CMD_W-1:0] cmd;
        logic [bto_pkg::ADDR_W-1:0] addr;
        logic [bto_pkg::DATA_W-1:0] data;
        logic [bto_pkg::BE_W-1:0] be;
        logic [bto_pkg::SEQ_W-1:0] seq_in;
        logic [bto_pkg::SEQ_W-1:0] seq_out;
        logic prio_dly;
        logic [IW-1:0] rr;
        logic posted;
        logic retry;
    } bto_dir_s;

    typedef struct packed {
        bto_dir_s [1:0] dir;
        logic [1:0] sy1;
        logic [1:0] sy2;
        logic [1:0] sy3;
    } bto_state_s;

    bto_state_s s;
    bto_state_s n;
    logic [1:0] rise;
    logic [1:0] f_push_v;
    logic [1:0] f_push_r;
    logic [1:0][PW-1:0] f_push_d;
    logic [1:0] f_pop_v;
    logic [1:0] f_pop_r;
    logic [1:0][PW-1:0] f_pop_d;
    logic [1:0][FW-1:0] f_lvl;
    logic [1:0] ld_post;
    logic [1:0] ld_dly;
    logic [1:0] cp_v;
    logic [1:0] has_cmp;

    // Bus clocks are only sampled; a bus event is taken on its clock's rising edge
    assign rise = s.sy2 & ~s.sy3;

    always_comb begin
        int fr [2];
        int lo [2];
        int hi [2];
        int pk [2];
        logic dup [2];
        logic [CW-1:0] infl [2];
        logic tk;
        int e;
        int j;
        for (int d = 0; d < 2; d++) begin
            fr[d] = 0;
            lo[d] = 0;
            hi[d] = 0;
            pk[d] = -1;
            dup[d] = 1'h0;
            infl[d] = '0;
        end
        tk = 1'h0;
        e = 0;
        j = 0;
        n = s;
        n.sy1 = pci_clk_in;
        n.sy2 = s.sy1;
        n.sy3 = s.sy2;
        init_ready_out = '0;
        f_push_v = '0;
        f_push_d = '0;
        f_pop_r = '0;
        ld_post = '0;
        ld_dly = '0;
        cp_v = '0;
        // Directions are handled alike; a delayed request waits on the other direction only for a free queue slot for its completion
        for (int d = 0; d < 2; d++) begin // see [RQ12] [RQ21] [RQ23]
            infl[d] = CW'(f_lvl[d]) + CW'(s.dir[d].busy && s.dir[d].src_post);
            cp_v[1-d] = s.dir[d].busy && !s.dir[d].src_post && !s.dir[d].cmp &&
                        tgt_ack_in[d] && rise[1-d]; // see [RQ4]
            for (int i = 0; i < DQ_DEPTH; i++) begin
                if (!s.dir[d].dq[i].vld) begin
                    if (fr[d] == 0) begin
                        lo[d] = i;
                    end
                    hi[d] = i;
                    fr[d] = fr[d] + 1;
                end else if (!s.dir[d].dq[i].cmp && s.dir[d].dq[i].cmd == init_cmd_in[d] &&
                             s.dir[d].dq[i].addr == init_addr_in[d]) begin
                    dup[d] = 1'h1; // see [RQ11]
                end
            end
        end
        for (int d = 0; d < 2; d++) begin
            e = 1 - d;
            n.dir[d].posted = 1'h0;
            n.dir[d].retry = 1'h0;
            // Posted acceptance looks only at posted space, never at delayed work
            init_ready_out[d] = rise[d] && (bto_pkg::is_posted(init_cmd_in[d]) ? f_push_r[d] :
                                (bto_pkg::is_dread(init_cmd_in[d]) ||
                                 bto_pkg::is_dwrite(init_cmd_in[d]))); // see [RQ13] [RQ14]
            tk = init_valid_in[d] && init_ready_out[d];
            f_push_d[d] = {s.dir[d].seq_in, init_cmd_in[d], init_addr_in[d], init_data_in[d], init_be_in[d]};
            if (tk && bto_pkg::is_posted(init_cmd_in[d])) begin
                f_push_v[d] = 1'h1; // see [RQ1]
                n.dir[d].posted = 1'h1;
                n.dir[d].seq_in = s.dir[d].seq_in + 1'h1;
            end else if (tk) begin
                n.dir[d].retry = 1'h1; // see [RQ2] [RQ3]
                // One slot stays reserved for the completion of the request in flight
                if (!dup[d] && fr[d] >= 2) begin
                    n.dir[d].dq[hi[d]] = {1'h1, 1'h0, init_cmd_in[d], init_addr_in[d],
                                          init_data_in[d], init_be_in[d], infl[d]}; // see [RQ16] [RQ18]
                end
            end
            if (cp_v[d]) begin
                n.dir[d].dq[lo[d]].vld = 1'h1;
                n.dir[d].dq[lo[d]].cmp = 1'h1;
                n.dir[d].dq[lo[d]].cmd = s.dir[e].cmd;
                n.dir[d].dq[lo[d]].addr = s.dir[e].addr;
                n.dir[d].dq[lo[d]].be = s.dir[e].be;
                if (bto_pkg::is_dread(s.dir[e].cmd)) begin
                    n.dir[d].dq[lo[d]].data = tgt_rdata_in[e]; // see [RQ4]
                    n.dir[d].dq[lo[d]].pend = infl[d]; // see [RQ17]
                end else begin
                    n.dir[d].dq[lo[d]].data = s.dir[e].data;
                    n.dir[d].dq[lo[d]].pend = '0; // see [RQ20]
                end
            end
            // Target bus answer; a retry leaves the entry and its place untouched
            if (s.dir[d].busy && rise[e] && tgt_ack_in[d]) begin
                n.dir[d].busy = 1'h0;
                if (s.dir[d].src_post) begin
                    n.dir[d].seq_out = s.dir[d].seq_out + 1'h1;
                    for (int i = 0; i < DQ_DEPTH; i++) begin
                        if (n.dir[d].dq[i].pend != '0) begin
                            n.dir[d].dq[i].pend = n.dir[d].dq[i].pend - 1'h1; // see [RQ16] [RQ17]
                        end
                    end
                end else begin
                    n.dir[d].dq[s.dir[d].slot].vld = 1'h0; // see [RQ8]
                end
            end else if (s.dir[d].busy && rise[e] && tgt_retry_in[d] && !s.dir[d].src_post) begin
                // Let another delayed entry go first next time
                n.dir[d].busy = 1'h0;
                n.dir[d].rr = IW'((int'(s.dir[d].slot) + 1) % DQ_DEPTH); // see [RQ9] [RQ8]
            end
            for (int k = 0; k < DQ_DEPTH; k++) begin
                j = (int'(s.dir[d].rr) + k) % DQ_DEPTH;
                if (pk[d] < 0 && s.dir[d].dq[j].vld && s.dir[d].dq[j].pend == '0 &&
                    (s.dir[d].dq[j].cmp || fr[e] >= 1)) begin
                    pk[d] = j; // see [RQ20] [RQ9]
                end
            end
            // Each queued write goes out alone with its own bytes and address
            if (!s.dir[d].busy && f_pop_v[d] && (pk[d] < 0 || !s.dir[d].prio_dly)) begin
                f_pop_r[d] = 1'h1;
                ld_post[d] = 1'h1;
                {n.dir[d].seq, n.dir[d].cmd, n.dir[d].addr, n.dir[d].data, n.dir[d].be} = f_pop_d[d]; // see [RQ5] [RQ6] [RQ7]
                n.dir[d].busy = 1'h1;
                n.dir[d].src_post = 1'h1;
                n.dir[d].cmp = 1'h0;
                n.dir[d].prio_dly = (pk[d] >= 0); // see [RQ19]
            end else if (!s.dir[d].busy && pk[d] >= 0) begin
                ld_dly[d] = 1'h1;
                n.dir[d].slot = IW'(pk[d]);
                n.dir[d].cmd = s.dir[d].dq[pk[d]].cmd;
                n.dir[d].addr = s.dir[d].dq[pk[d]].addr;
                n.dir[d].data = s.dir[d].dq[pk[d]].data;
                n.dir[d].be = s.dir[d].dq[pk[d]].be;
                n.dir[d].cmp = s.dir[d].dq[pk[d]].cmp;
                n.dir[d].busy = 1'h1;
                n.dir[d].src_post = 1'h0;
                n.dir[d].prio_dly = 1'h0; // see [RQ19]
            end
        end
    end

    always_comb begin
        has_cmp = '0;
        for (int d = 0; d < 2; d++) begin
            for (int i = 0; i < DQ_DEPTH; i++) begin
                if (s.dir[d].dq[i].vld && s.dir[d].dq[i].cmp) begin
                    has_cmp[d] = 1'h1;
                end
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (reset_in);

    for (genvar g = 0; g < 2; g++) begin : g_dir
        assign init_posted_out[g] = s.dir[g].posted;
        assign init_retry_out[g] = s.dir[g].retry;
        assign tgt_valid_out[g] = s.dir[g].busy;
        assign tgt_cmp_out[g] = s.dir[g].cmp;
        assign tgt_cmd_out[g] = s.dir[g].cmd;
        assign tgt_addr_out[g] = s.dir[g].addr;
        assign tgt_data_out[g] = s.dir[g].data;
        assign tgt_be_out[g] = s.dir[g].be;

        bto_post_fifo #(
            .W(PW),
            .DEPTH(PW_DEPTH)
        ) u_post (
            .core_clk_in(core_clk_in),
            .reset_in(reset_in),
            .push_valid_in(f_push_v[g]),
            .push_ready_out(f_push_r[g]),
            .push_data_in(f_push_d[g]),
            .pop_valid_out(f_pop_v[g]),
            .pop_ready_in(f_pop_r[g]),
            .pop_data_out(f_pop_d[g]),
            .level_out(f_lvl[g])
        );

        sequence s_dtake;
            init_valid_in[g] && init_ready_out[g] && !bto_pkg::is_posted(init_cmd_in[g]);
        endsequence
        sequence s_ptake;
            init_valid_in[g] && init_ready_out[g] && bto_pkg::is_posted(init_cmd_in[g]);
        endsequence
        sequence s_req_done;
            s.dir[g].busy && !s.dir[g].src_post && !s.dir[g].cmp && tgt_ack_in[g] && rise[1-g];
        endsequence

        property p_retry;
            s_dtake |=> init_retry_out[g] && !init_posted_out[g];
        endproperty
        a_retry: assert property (p_retry) // see [RQ3]
            else $error("delayed request not answered by retry");

        property p_posted;
            s_ptake |=> init_posted_out[g] && !init_retry_out[g];
        endproperty
        a_posted: assert property (p_posted) // see [RQ1]
            else $error("posted write not completed at source");

        property p_accept;
            init_valid_in[g] && bto_pkg::is_posted(init_cmd_in[g]) && f_lvl[g] != FW'(PW_DEPTH) && rise[g]
                |-> init_ready_out[g];
        endproperty
        a_accept: assert property (p_accept) // see [RQ14]
            else $error("posted write refused with space free");

        property p_order;
            s.dir[g].busy && s.dir[g].src_post && tgt_ack_in[g] && rise[1-g] |-> s.dir[g].seq == s.dir[g].seq_out;
        endproperty
        a_order: assert property (p_order) // see [RQ15]
            else $error("posted write completed out of order");

        property p_dly_bar;
            s.dir[g].busy && !s.dir[g].src_post && !s.dir[g].cmp |-> s.dir[g].dq[s.dir[g].slot].pend == '0;
        endproperty
        a_dly_bar: assert property (p_dly_bar) // see [RQ16] [RQ18]
            else $error("delayed request passed a posted write");

        property p_cmp_bar;
            s.dir[g].busy && s.dir[g].cmp && bto_pkg::is_dread(s.dir[g].cmd) |->
                s.dir[g].dq[s.dir[g].slot].pend == '0 && !f_pop_r[g];
        endproperty
        a_cmp_bar: assert property (p_cmp_bar) // see [RQ17]
            else $error("read completion passed a posted write");

        property p_cmp_dir;
            s_req_done |=> has_cmp[1-g];
        endproperty
        a_cmp_dir: assert property (p_cmp_dir) // see [RQ4] [RQ21]
            else $error("completion not queued in reverse direction");

        property p_keep;
            s.dir[g].busy && !s.dir[g].src_post && tgt_retry_in[g] && !tgt_ack_in[g] && rise[1-g]
                |=> s.dir[g].dq[$past(s.dir[g].slot)].vld;
        endproperty
        a_keep: assert property (p_keep) // see [RQ8]
            else $error("retried request lost its entry");

        property p_whole;
            ld_post[g] |=> {tgt_addr_out[g], tgt_data_out[g], tgt_be_out[g]} ==
                $past(f_pop_d[g][bto_pkg::POST_LOW_W-1:0]);
        endproperty
        a_whole: assert property (p_whole) // see [RQ5] [RQ6] [RQ7]
            else $error("posted write altered on forwarding");

        property p_fair;
            !s.dir[g].busy && f_pop_v[g] && !s.dir[g].prio_dly |-> ld_post[g];
        endproperty
        a_fair: assert property (p_fair) // see [RQ19]
            else $error("posted write denied its turn");
    end
endmodule : bto_bridge

// ### include/bto_pkg.sv
package bto_pkg;
    // Transfer field widths
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam int CMD_W = 4;
    localparam int SEQ_W = 8;
    // Posted queue payload: {seq, cmd, addr, data, be}
    localparam int POST_LOW_W = ADDR_W + DATA_W + BE_W;
    localparam int POST_W = SEQ_W + CMD_W + POST_LOW_W;
    // Bus command codes
    localparam logic [CMD_W-1:0] CMD_IO_RD = 4'h2;
    localparam logic [CMD_W-1:0] CMD_IO_WR = 4'h3;
    localparam logic [CMD_W-1:0] CMD_MEM_RD = 4'h6;
    localparam logic [CMD_W-1:0] CMD_MEM_WR = 4'h7;
    localparam logic [CMD_W-1:0] CMD_CFG_RD = 4'ha;
    localparam logic [CMD_W-1:0] CMD_CFG_WR = 4'hb;
    localparam logic [CMD_W-1:0] CMD_MEM_RDM = 4'hc;
    localparam logic [CMD_W-1:0] CMD_MEM_RDL = 4'he;
    localparam logic [CMD_W-1:0] CMD_MEM_WRI = 4'hf;

    function automatic logic is_posted(input logic [CMD_W-1:0] c);
        return (c == CMD_MEM_WR) || (c == CMD_MEM_WRI); // see [RQ1]
    endfunction : is_posted

    function automatic logic is_dwrite(input logic [CMD_W-1:0] c);
        return (c == CMD_IO_WR) || (c == CMD_CFG_WR); // see [RQ2]
    endfunction : is_dwrite

    function automatic logic is_dread(input logic [CMD_W-1:0] c);
        return (c == CMD_IO_RD) || (c == CMD_MEM_RD) || (c == CMD_CFG_RD) ||
               (c == CMD_MEM_RDM) || (c == CMD_MEM_RDL); // see [RQ3]
    endfunction : is_dread
endpackage : bto_pkg

// ### rtl/bto_post_fifo.sv
`timescale 1ns/10ps
module bto_post_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic reset_in,
    // Fill side
    input wire logic push_valid_in,
    output logic push_ready_out,
    input wire logic [W-1:0] push_data_in,
    // Drain side
    output logic pop_valid_out,
    input wire logic pop_ready_in,
    output logic [W-1:0] pop_data_out,
    output logic [$clog2(DEPTH+1)-1:0] level_out
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int LW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [LW-1:0] cnt;
    } bto_fifo_s;

    bto_fifo_s s;
    bto_fifo_s n;
    logic push;
    logic pop;

    assign push_ready_out = (s.cnt != LW'(DEPTH));
    assign pop_valid_out = (s.cnt != '0);
    assign pop_data_out = s.mem[s.rp];
    assign level_out = s.cnt;
    assign push = push_valid_in && push_ready_out;
    assign pop = pop_valid_out && pop_ready_in;

    // Strict first in, first out: entries leave exactly as they came
    always_comb begin
        n = s;
        if (push) begin
            n.mem[s.wp] = push_data_in;
            n.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + 1'h1; // see [RQ15]
        end
        if (pop) begin
            n.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + 1'h1;
        end
        n.cnt = s.cnt + LW'(push) - LW'(pop);
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end
endmodule : bto_post_fifo

// ### verification/bto_far_target.sv
`timescale 1ns/10ps
module bto_far_target #(
    parameter int SEED = 1
) (
    // Clock
    input wire logic core_clk_in,
    // Item presented by the bridge
    input wire logic present_in,
    // Behaviour controls
    input wire logic slow_in,
    input wire logic retry_en_in,
    // Target answer
    output logic ack_out,
    output logic retry_out,
    output logic [31:0] rdata_out
);
    logic [31:0] lfsr = 32'(SEED);
    logic busy = 1'b0;
    logic do_retry = 1'b0;
    logic flip = 1'b0;
    int cnt = 0;
    int rcnt = 0;
    initial begin
        ack_out = 1'b0;
        retry_out = 1'b0;
        rdata_out = 32'h0;
    end
    always @(negedge core_clk_in) begin
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        if (!present_in) begin
            ack_out = 1'b0;
            retry_out = 1'b0;
            busy = 1'b0;
            // Released data lines keep changing so a stale value never looks valid
            rdata_out = lfsr;
        end else begin
            if (!busy) begin
                busy = 1'b1;
                rcnt = 0;
                // Answer never waits on any mastering of our own
                cnt = slow_in ? int'(lfsr[5:0]) : 0;
                do_retry = retry_en_in & flip;
                flip = ~flip;
            end else if (cnt > 0) begin
                cnt--;
            end
            if (cnt == 0) begin
                retry_out = do_retry;
                ack_out = !do_retry;
                // Retry spans more than one bus clock so it is surely seen
                rcnt++;
                if (rcnt > 30) begin
                    do_retry = 1'b0;
                end
            end
        end
    end
endmodule : bto_far_target

// ### verification/bto_bridge_bench.sv
`timescale 1ns/10ps
module bto_bridge_bench;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] pci_clk = 2'b00;
    logic [1:0] init_valid = '0;
    logic [1:0][3:0] init_cmd = '0;
    logic [1:0][31:0] init_addr = '0;
    logic [1:0][31:0] init_data = '0;
    logic [1:0][3:0] init_be = '0;
    logic [1:0] init_ready, init_posted, init_retry, tgt_valid, tgt_cmp;
    logic [1:0][3:0] tgt_cmd, tgt_be;
    logic [1:0][31:0] tgt_addr, tgt_data;
    wire [1:0] tgt_ack, tgt_retry;
    wire [1:0][31:0] tgt_rdata;
    logic slow = 1'b0;
    logic retry_en = 1'b0;
    logic [31:0] seed = 32'hcf1b;
    int bad_count = 0;
    int checks_done = 0;
    int uniq = 0;
    int posted_in[2], posted_done[2], ack_snap[2];
    logic [71:0] posted_exp[2][$];
    logic [3:0] cur_cmd[2];
    logic [31:0] last_rd[2];
    logic [3:0] cmds[9] = '{4'h2, 4'h3, 4'h6, 4'h7, 4'ha, 4'hb, 4'hc, 4'he, 4'hf};
    logic [1:0] pend_v = '0, cmpl_v = '0, prev_v = '0, ack_seen = '0, cur_cmp = '0;
    typedef struct packed {
        logic [3:0] cmd;
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0] be;
        int snap;
    } bto_exp_s;
    bto_exp_s pend[2], cmpl[2];

    always #2.5 core_clk = ~core_clk;
    always #62.5 pci_clk[0] = ~pci_clk[0];
    initial begin
        #17;
        forever #62.5 pci_clk[1] = ~pci_clk[1];
    end

    bto_bridge u_dut (.core_clk_in(core_clk), .reset_in(rst), .pci_clk_in(pci_clk),
        .init_valid_in(init_valid), .init_cmd_in(init_cmd), .init_addr_in(init_addr),
        .init_data_in(init_data), .init_be_in(init_be), .init_ready_out(init_ready),
        .init_posted_out(init_posted), .init_retry_out(init_retry), .tgt_valid_out(tgt_valid),
        .tgt_cmp_out(tgt_cmp), .tgt_cmd_out(tgt_cmd), .tgt_addr_out(tgt_addr), .tgt_data_out(tgt_data),
        .tgt_be_out(tgt_be), .tgt_ack_in(tgt_ack), .tgt_retry_in(tgt_retry), .tgt_rdata_in(tgt_rdata));
    bto_far_target #(.SEED(32'h1d3)) u_far0 (.core_clk_in(core_clk), .present_in(tgt_valid[0]),
        .slow_in(slow), .retry_en_in(retry_en), .ack_out(tgt_ack[0]), .retry_out(tgt_retry[0]),
        .rdata_out(tgt_rdata[0]));
    bto_far_target #(.SEED(32'h7a5)) u_far1 (.core_clk_in(core_clk), .present_in(tgt_valid[1]),
        .slow_in(slow), .retry_en_in(retry_en), .ack_out(tgt_ack[1]), .retry_out(tgt_retry[1]),
        .rdata_out(tgt_rdata[1]));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    function automatic int kind(input logic [3:0] c);
        case (c)
            4'h7, 4'hf: return 1;
            4'h2, 4'h6, 4'ha, 4'hc, 4'he: return 2;
            4'h3, 4'hb: return 3;
            default: return 0;
        endcase
    endfunction : kind

    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        if (bad_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    task automatic issue(input int d, input logic [3:0] c, input logic [31:0] a);
        int k;
        int n;
        logic took;
        logic [31:0] r;
        k = kind(c);
        took = 1'b0;
        // Initiator keeps one delayed request open at a time
        for (n = 0; n < 4000 && k >= 2 && (pend_v[d] || cmpl_v[1-d]); n++) @(negedge core_clk);
        if (k >= 2 && (pend_v[d] || cmpl_v[1-d])) begin
            chk(72'h1, 72'h0);
            end_sim();
        end
        @(negedge core_clk);
        seed = xs(seed);
        r = seed;
        init_valid[d] = 1'b1;
        init_cmd[d] = c;
        init_addr[d] = a;
        init_data[d] = r;
        init_be[d] = r[7:4];
        for (n = 0; n < (k != 0 ? 4000 : 60) && !took; n++) begin
            @(posedge core_clk);
            took = (init_ready[d] === 1'b1);
        end
        @(negedge core_clk);
        init_valid[d] = 1'b0;
        if (took && k == 1) begin
            posted_exp[d].push_back({c, a, r, r[7:4]});
            posted_in[d]++;
        end
        if (took && k >= 2) begin
            pend[d] = '{c, a, r, r[7:4], posted_in[d]};
            pend_v[d] = 1'b1;
        end
        chk(72'(took), 72'(k != 0));
        chk(72'({init_posted[d], init_retry[d]}), 72'({took && k == 1, took && k >= 2}));
        if (!took && k != 0) end_sim();
    endtask : issue

    task automatic drive(input int d, input int phase);
        int i;
        logic [3:0] c;
        for (i = 0; i < (phase == 0 ? 16 : 40); i++) begin
            seed = xs(seed);
            c = phase == 0 ? 4'(i) : (seed[1:0] != 2'b00 ? 4'h7 : cmds[seed[11:8] % 9]);
            // In phase 0, a posted write to 32'h40 just ahead of every command forces queue ordering
            if (phase == 0) issue(d, 4'h7, 32'h40);
            uniq++;
            issue(d, c, kind(c) == 1 ? 32'h40 + {27'h0, seed[4], 4'h0} : {3'h0, 1'(d), 16'h0, 12'(uniq << 2)});
        end
        // A closing read flushes every posted write sent before it
        issue(d, 4'h6, {3'h0, 1'(d), 28'hffffff0});
    endtask : drive

    task automatic present(input int d);
        int k;
        cur_cmd[d] = tgt_cmd[d];
        cur_cmp[d] = tgt_cmp[d];
        k = kind(tgt_cmd[d]);
        if (tgt_cmp[d]) begin
            chk(72'({cmpl_v[d], tgt_cmd[d], tgt_addr[d]}), 72'({1'b1, cmpl[d].cmd, cmpl[d].addr}));
            if (k == 2) chk(72'({tgt_data[d], posted_done[d] >= cmpl[d].snap}), 72'({cmpl[d].data, 1'b1}));
        end else if (k == 1) begin
            chk({tgt_cmd[d], tgt_addr[d], tgt_data[d], tgt_be[d]},
                posted_exp[d].size() > 0 ? posted_exp[d][0] : 72'bx);
        end else begin
            chk(72'({pend_v[d], tgt_cmd[d], tgt_addr[d], posted_done[d] >= pend[d].snap}),
                72'({1'b1, pend[d].cmd, pend[d].addr, 1'b1}));
            if (k == 3) chk(72'({tgt_data[d], tgt_be[d]}), 72'({pend[d].data, pend[d].be}));
        end
    endtask : present

    task automatic finish_item(input int d);
        if (cur_cmp[d]) begin
            cmpl_v[d] = 1'b0;
        end else if (kind(cur_cmd[d]) == 1) begin
            if (posted_exp[d].size() > 0) void'(posted_exp[d].pop_front());
            posted_done[d]++;
        end else begin
            cmpl[1-d] = pend[d];
            cmpl[1-d].data = last_rd[d];
            // Write completions may pass posted writes
            cmpl[1-d].snap = kind(cur_cmd[d]) == 2 ? ack_snap[d] : 0;
            cmpl_v[1-d] = 1'b1;
            pend_v[d] = 1'b0;
        end
    endtask : finish_item

    always @(posedge core_clk) begin
        for (int d = 0; d < 2; d++) begin
            if (!rst && tgt_valid[d] && !prev_v[d]) present(d);
            if (tgt_valid[d] && tgt_ack[d]) begin
                ack_seen[d] = 1'b1;
                last_rd[d] = tgt_rdata[d];
                // Posted writes taken at the same edge count as later
                ack_snap[d] = posted_in[1-d];
            end
            if (!tgt_valid[d] && prev_v[d] && ack_seen[d]) finish_item(d);
            if (!tgt_valid[d]) ack_seen[d] = 1'b0;
            prev_v[d] = tgt_valid[d];
        end
    end

    initial begin : main_seq
        int n;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        repeat (6) @(negedge core_clk);
        fork
            drive(0, 0);
            drive(1, 0);
        join
        @(posedge core_clk);
        slow = 1'b1;
        retry_en = 1'b1;
        fork
            drive(0, 1);
            drive(1, 1);
        join
        for (n = 0; n < 20000 && (posted_exp[0].size() + posted_exp[1].size() != 0 || pend_v || cmpl_v); n++) begin
            @(posedge core_clk);
        end
        chk(72'({pend_v, cmpl_v}), 72'h0);
        chk(72'(posted_exp[0].size() + posted_exp[1].size()), 72'h0);
        end_sim();
    end
endmodule : bto_bridge_bench
